/* File: aiag_assertions.sv */
// Checker: port timing and mapping of the alarm gating block
`timescale 1ns/1ps
module aiag_checker
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] fault_short,
   input wire logic [3:0] sample_vld,
   input wire logic [3:0] diag_alarm,
   input wire logic [3:0] diag_log,
   input wire logic [11:0] diag_cause,
   input wire logic [3:0] proc_alarm,
   input wire logic [7:0] proc_cause
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Filter needs the pin steady, so nothing before stage four
   sequence s_quiet;
      !diag_cause[0] [*4];
   endsequence
   property p_quiet;
      $rose(fault_short[0]) |-> s_quiet;
   endproperty
   a_quiet: assert property (p_quiet) else $error("early short alarm");
   property p_lat;
      diag_cause[0] |-> $past(fault_short[0], 5);
   endproperty
   a_lat: assert property (p_lat) else $error("short alarm without pin");
   property p_pulse;
      diag_alarm[0] |=> !diag_alarm[0];
   endproperty
   a_pulse: assert property (p_pulse) else $error("diag alarm too long");
   property p_log;
      diag_log == diag_alarm;
   endproperty
   a_log: assert property (p_log) else $error("log differs from alarm");
   property p_dmap;
      diag_alarm == {|diag_cause[11:9], |diag_cause[8:6], |diag_cause[5:3], |diag_cause[2:0]};
   endproperty
   a_dmap: assert property (p_dmap) else $error("diag cause mismatch");
   property p_pmap;
      proc_alarm == {|proc_cause[7:6], |proc_cause[5:4], |proc_cause[3:2], |proc_cause[1:0]};
   endproperty
   a_pmap: assert property (p_pmap) else $error("proc cause mismatch");
   property p_pvld0;
      proc_alarm[0] |-> $past(sample_vld[0]);
   endproperty
   a_pvld0: assert property (p_pvld0) else $error("proc alarm without sample");
   property p_pvld1;
      (proc_cause[3:2] != 2'h0) |-> $past(sample_vld[1]);
   endproperty
   a_pvld1: assert property (p_pvld1) else $error("proc cause without sample");
endmodule // aiag_checker
bind aiag_top aiag_checker u_chk (.clk(clk), .rst(rst), .fault_short(fault_short),
   .sample_vld(sample_vld), .diag_alarm(diag_alarm), .diag_log(diag_log),
   .diag_cause(diag_cause), .proc_alarm(proc_alarm), .proc_cause(proc_cause));

/* File: aiag_ctrl_model.sv */
// Controller model: collects reported diagnostic alarm causes
`timescale 1ns/1ps
module aiag_ctrl_model
(
   input wire logic clk,
   input wire logic clr,
   input wire logic [3:0] diag_alarm,
   input wire logic [11:0] diag_cause,
   output logic [11:0] seen_ff
);
   logic [11:0] nxt_seen;
   // Causes count only beside an alarm, as a receiver would see them
   always_comb
   begin
      nxt_seen = clr ? 12'h000 : seen_ff | (diag_cause & {12{|diag_alarm}});
   end
   always_ff @(posedge clk)
   begin
      seen_ff <= nxt_seen;
   end
endmodule // aiag_ctrl_model

/* File: aiag_pkg.sv */
// Package: register map, field positions and encodings for the alarm gating block
package aiag_pkg;
   localparam int NUM_CH = 4;
   localparam int ADDR_W = 8;
   // Register offsets, one word per channel where noted
   localparam logic [7:0] OFS_CFG_BASE = 8'h00;
   localparam logic [7:0] OFS_LOLIM_BASE = 8'h10;
   localparam logic [7:0] OFS_HILIM_BASE = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h30;
   localparam logic [7:0] OFS_MASK = 8'h34;
   localparam logic [7:0] OFS_LEVEL = 8'h38;
   localparam logic [7:0] OFS_STRIDE = 8'h04;
   // Channel config fields
   localparam int CFG_CHDIAG = 0;
   localparam int CFG_SHORT = 1;
   localparam int CFG_BREAK = 2;
   localparam int CFG_OVLD = 3;
   localparam int CFG_LOW = 4;
   localparam int CFG_HIGH = 5;
   localparam int CFG_RANGE = 6;
   localparam int CFG_W = 8;
   // Value range encodings
   localparam logic [1:0] RNG_POS15 = 2'h0;
   localparam logic [1:0] RNG_SIGNED = 2'h1;
   localparam logic [1:0] RNG_UNS16 = 2'h2;
   // Reset values
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [15:0] LOLIM_RST = 16'h0000;
   localparam logic [15:0] HILIM_RST = 16'h7fff;
   localparam logic [7:0] MASK_RST = 8'h00;
   // Status layout: bits [3:0] diagnostic per channel, [7:4] process per channel
   localparam int ST_W = 2 * NUM_CH;
endpackage

/* File: aiag_top.sv */
// Analog input alarm gating: per-channel enables, limit compare, alarm events, registers
// Operation
// - Master diagnosis enable 0 blocks every alarm of that channel.
// - Short circuit enable 0: no diagnostic alarm, no log entry.
// - Short circuit enable 1 with master: diagnostic alarm plus log entry.
// - Line break enable 0: no diagnostic alarm, no log entry.
// - Line break enable 1 with master: diagnostic alarm plus log entry.
// - Overload enable 0: no diagnostic alarm, no log entry.
// - Overload enable 1 with master: diagnostic alarm plus log entry.
// - Lower limit enable 0: no process alarm below lower limit.
// - Lower limit enable 1 with master: process alarm, no log entry.
// - Upper limit enable 0: no process alarm above upper limit.
// - Upper limit enable 1 with master: process alarm, no log entry.
// - Lower limit is 16 bits in the channel's value range; controller keeps it valid.
// - Upper limit is 16 bits in the same ranges; controller keeps it valid.
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module aiag_top
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic [3:0] fault_short,
   input wire logic [3:0] fault_break,
   input wire logic [3:0] fault_ovld,
   input wire logic [3:0] sample_vld,
   input wire logic [63:0] sample,
   output logic [3:0] diag_alarm,
   output logic [3:0] diag_log,
   output logic [11:0] diag_cause,
   output logic [3:0] proc_alarm,
   output logic [7:0] proc_cause,
   output logic irq
);
   localparam int N = aiag_pkg::NUM_CH;

   // Fault pins come from outside: three-stage synchronisers
   logic [3:0] s1_ff [3];
   logic [3:0] s2_ff [3];
   logic [3:0] s3_ff [3];
   logic [3:0] flt_ff [3];
   logic [3:0] nxt_s1 [3];
   logic [3:0] nxt_flt [3];
   logic [3:0] nxt_s2 [3];
   logic [3:0] nxt_s3 [3];

   logic [aiag_pkg::CFG_W-1:0] cfg_ff [N];
   logic [15:0] lolim_ff [N];
   logic [15:0] hilim_ff [N];
   logic [aiag_pkg::ST_W-1:0] status_ff;
   logic [aiag_pkg::ST_W-1:0] mask_ff;
   logic [aiag_pkg::CFG_W-1:0] nxt_cfg [N];
   logic [15:0] nxt_lolim [N];
   logic [15:0] nxt_hilim [N];
   logic [aiag_pkg::ST_W-1:0] nxt_status;
   logic [aiag_pkg::ST_W-1:0] nxt_mask;
   logic [31:0] nxt_rdata;

   logic [3:0] nxt_diag_alarm;
   logic [3:0] nxt_proc_alarm;
   logic [11:0] nxt_diag_cause;
   logic [7:0] nxt_proc_cause;
   logic nxt_irq;

   // Synchroniser next values
   always_comb
   begin
      for (int k = 0; k < 3; k++)
      begin
         nxt_s1[k] = (k == 0) ? fault_short : ((k == 1) ? fault_break : fault_ovld);
         nxt_s2[k] = s1_ff[k];
         nxt_s3[k] = s2_ff[k];
         // A change counts only once stages two and three agree
         nxt_flt[k] = flt_ff[k];
         for (int c = 0; c < N; c++)
         begin
            if (s2_ff[k][c] == s3_ff[k][c])
            begin
               nxt_flt[k][c] = s3_ff[k][c];
            end
         end
      end
   end

   always_ff @(posedge clk)
   begin
      for (int k = 0; k < 3; k++)
      begin
         if (rst)
         begin
            s1_ff[k] <= 4'h0;
            s2_ff[k] <= 4'h0;
            s3_ff[k] <= 4'h0;
            flt_ff[k] <= 4'h0;
         end
         else
         begin
            s1_ff[k] <= nxt_s1[k];
            s2_ff[k] <= nxt_s2[k];
            s3_ff[k] <= nxt_s3[k];
            flt_ff[k] <= nxt_flt[k];
         end
      end
   end

   // Previous filtered levels, so a fault raises one event at its onset
   logic [3:0] prev_ff [3];
   logic [3:0] nxt_prev [3];

   always_comb
   begin
      for (int k = 0; k < 3; k++)
      begin
         nxt_prev[k] = flt_ff[k];
      end
   end

   always_ff @(posedge clk)
   begin
      for (int k = 0; k < 3; k++)
      begin
         if (rst)
         begin
            prev_ff[k] <= 4'h0;
         end
         else
         begin
            prev_ff[k] <= nxt_prev[k];
         end
      end
   end

   // Alarm gating and limit compare
   always_comb
   begin
      logic [15:0] smp;
      logic [1:0] rng;
      logic below;
      logic above;
      logic ms;
      logic mb;
      logic mo;
      logic ml;
      logic mh;
      smp = 16'h0000;
      rng = 2'h0;
      below = 1'b0;
      above = 1'b0;
      ms = 1'b0;
      mb = 1'b0;
      mo = 1'b0;
      ml = 1'b0;
      mh = 1'b0;
      nxt_diag_alarm = 4'h0;
      nxt_proc_alarm = 4'h0;
      nxt_diag_cause = 12'h000;
      nxt_proc_cause = 8'h00;
      for (int c = 0; c < N; c++)
      begin
         smp = sample[c*16 +: 16];
         rng = cfg_ff[c][aiag_pkg::CFG_RANGE +: 2];
         // Signed compare only for the bipolar range; limits trusted in range
         if (rng == aiag_pkg::RNG_SIGNED)
         begin
            below = $signed(smp) < $signed(lolim_ff[c]);
            above = $signed(smp) > $signed(hilim_ff[c]);
         end
         else
         begin
            below = smp < lolim_ff[c];
            above = smp > hilim_ff[c];
         end
         ms = cfg_ff[c][aiag_pkg::CFG_CHDIAG] & cfg_ff[c][aiag_pkg::CFG_SHORT];
         mb = cfg_ff[c][aiag_pkg::CFG_CHDIAG] & cfg_ff[c][aiag_pkg::CFG_BREAK];
         mo = cfg_ff[c][aiag_pkg::CFG_CHDIAG] & cfg_ff[c][aiag_pkg::CFG_OVLD];
         ml = cfg_ff[c][aiag_pkg::CFG_CHDIAG] & cfg_ff[c][aiag_pkg::CFG_LOW];
         mh = cfg_ff[c][aiag_pkg::CFG_CHDIAG] & cfg_ff[c][aiag_pkg::CFG_HIGH];
         nxt_diag_cause[c*3] = ms & flt_ff[0][c] & ~prev_ff[0][c];
         nxt_diag_cause[c*3+1] = mb & flt_ff[1][c] & ~prev_ff[1][c];
         nxt_diag_cause[c*3+2] = mo & flt_ff[2][c] & ~prev_ff[2][c];
         nxt_proc_cause[c*2] = ml & sample_vld[c] & below;
         nxt_proc_cause[c*2+1] = mh & sample_vld[c] & above;
         nxt_diag_alarm[c] = |nxt_diag_cause[c*3 +: 3];
         nxt_proc_alarm[c] = |nxt_proc_cause[c*2 +: 2];
      end
   end

   // Configuration and limit registers
   always_comb
   begin
      logic [7:0] ofs;
      ofs = 8'h00;
      for (int c = 0; c < N; c++)
      begin
         ofs = 8'(c) * aiag_pkg::OFS_STRIDE;
         nxt_cfg[c] = cfg_ff[c];
         nxt_lolim[c] = lolim_ff[c];
         nxt_hilim[c] = hilim_ff[c];
         if (wr && addr == aiag_pkg::OFS_CFG_BASE + ofs)
         begin
            nxt_cfg[c] = wdata[aiag_pkg::CFG_W-1:0];
         end
         // Limits taken as written; range is the controller's duty
         if (wr && addr == aiag_pkg::OFS_LOLIM_BASE + ofs)
         begin
            nxt_lolim[c] = wdata[15:0];
         end
         if (wr && addr == aiag_pkg::OFS_HILIM_BASE + ofs)
         begin
            nxt_hilim[c] = wdata[15:0];
         end
      end
   end

   always_ff @(posedge clk)
   begin
      for (int c = 0; c < N; c++)
      begin
         if (rst)
         begin
            cfg_ff[c] <= aiag_pkg::CFG_RST;
            lolim_ff[c] <= aiag_pkg::LOLIM_RST;
            hilim_ff[c] <= aiag_pkg::HILIM_RST;
         end
         else
         begin
            cfg_ff[c] <= nxt_cfg[c];
            lolim_ff[c] <= nxt_lolim[c];
            hilim_ff[c] <= nxt_hilim[c];
         end
      end
   end

   // Status, mask and interrupt level
   always_comb
   begin
      logic [aiag_pkg::ST_W-1:0] ev;
      ev = {nxt_proc_alarm, nxt_diag_alarm};
      nxt_mask = mask_ff;
      // Set wins over a write-one clear, so a racing clear loses no event
      nxt_status = status_ff;
      if (wr && addr == aiag_pkg::OFS_STATUS)
      begin
         nxt_status = status_ff & ~wdata[aiag_pkg::ST_W-1:0];
      end
      nxt_status = nxt_status | ev;
      if (wr && addr == aiag_pkg::OFS_MASK)
      begin
         nxt_mask = wdata[aiag_pkg::ST_W-1:0];
      end
      // Built from next values so irq moves on the same edge as status
      nxt_irq = |(nxt_status & nxt_mask);
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         status_ff <= 8'h00;
         mask_ff <= aiag_pkg::MASK_RST;
         irq <= 1'b0;
      end
      else
      begin
         status_ff <= nxt_status;
         mask_ff <= nxt_mask;
         irq <= nxt_irq;
      end
   end

   // Read data: one cycle after the strobe, zero otherwise
   always_comb
   begin
      logic [7:0] ofs;
      ofs = 8'h00;
      nxt_rdata = 32'h0000_0000;
      for (int c = 0; c < N; c++)
      begin
         ofs = 8'(c) * aiag_pkg::OFS_STRIDE;
         if (rd && addr == aiag_pkg::OFS_CFG_BASE + ofs)
         begin
            nxt_rdata = {24'h000000, cfg_ff[c]};
         end
         if (rd && addr == aiag_pkg::OFS_LOLIM_BASE + ofs)
         begin
            nxt_rdata = {16'h0000, lolim_ff[c]};
         end
         if (rd && addr == aiag_pkg::OFS_HILIM_BASE + ofs)
         begin
            nxt_rdata = {16'h0000, hilim_ff[c]};
         end
      end
      if (rd && addr == aiag_pkg::OFS_STATUS)
      begin
         nxt_rdata = {24'h000000, status_ff};
      end
      if (rd && addr == aiag_pkg::OFS_MASK)
      begin
         nxt_rdata = {24'h000000, mask_ff};
      end
      if (rd && addr == aiag_pkg::OFS_LEVEL)
      begin
         nxt_rdata = {20'h00000, flt_ff[2], flt_ff[1], flt_ff[0]};
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rdata <= 32'h0000_0000;
      end
      else
      begin
         rdata <= nxt_rdata;
      end
   end

   // Alarm event outputs, one cycle each
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         diag_alarm <= 4'h0;
         diag_log <= 4'h0;
         diag_cause <= 12'h000;
         proc_alarm <= 4'h0;
         proc_cause <= 8'h00;
      end
      else
      begin
         diag_alarm <= nxt_diag_alarm;
         diag_log <= nxt_diag_alarm;
         diag_cause <= nxt_diag_cause;
         proc_alarm <= nxt_proc_alarm;
         proc_cause <= nxt_proc_cause;
      end
   end
endmodule // aiag_top

/* File: analog_input_alarm_gating_bench.sv */
// Bench: fault gating, limit compares, registers and interrupt
`timescale 1ns/1ps
module analog_input_alarm_gating_bench;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, clr = 1'b1, irq;
   logic [7:0] addr = 8'h00, proc_cause;
   logic [31:0] wdata = 32'h0, rdata;
   logic [11:0] flt = 12'h000, diag_cause, seen;
   logic [3:0] sample_vld = 4'h0, diag_alarm, diag_log, proc_alarm;
   logic [63:0] sample = 64'h0;
   int err_count = 0, checks = 0, cyc = 0;
   always #50 clk = ~clk;
   aiag_top u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .fault_short(flt[3:0]), .fault_break(flt[7:4]), .fault_ovld(flt[11:8]),
      .sample_vld(sample_vld), .sample(sample), .diag_alarm(diag_alarm), .diag_log(diag_log),
      .diag_cause(diag_cause), .proc_alarm(proc_alarm), .proc_cause(proc_cause), .irq(irq));
   aiag_ctrl_model u_ctrl (.clk(clk), .clr(clr), .diag_alarm(diag_alarm),
      .diag_cause(diag_cause), .seen_ff(seen));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   function automatic logic [7:0] exp_proc(input logic [7:0] c, input logic [15:0] s, lo, hi);
      logic sg;
      logic b;
      logic a;
      sg = (c[7:6] == 2'h1);
      b = sg ? ($signed(s) < $signed(lo)) : (s < lo);
      a = sg ? ($signed(s) > $signed(hi)) : (s > hi);
      return {6'h00, a & c[5] & c[0], b & c[4] & c[0]};
   endfunction
   // Limits stay inside the range the channel is set to
   function automatic logic [15:0] pick(input logic [1:0] r);
      logic [15:0] v;
      v = 16'($urandom);
      if (r == 2'h0) v[15] = 1'b0;
      if (r == 2'h1 && v == 16'h8000) v = 16'h8001;
      return v;
   endfunction
   task summarize;
      $display("errors %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_count++;
         summarize();
      end
   end
   initial
   begin
      int k, i, ch, sel;
      logic [7:0] cf;
      logic [15:0] lo, hi, s;
      logic [63:0] v;
      logic [11:0] e;
      k = $urandom(32'ha5748262);
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1 rd_chk(8'h00, 32'h0);
      rd_chk(8'h10, 32'h0);
      rd_chk(8'h20, 32'h7fff);
      rd_chk(8'hfc, 32'h0);
      wr_reg(aiag_pkg::OFS_MASK, 32'h1);
      for (k = 0; k < 3; k++)
         for (i = 0; i < 4; i++)
         begin
            e = (i == 3) ? 12'(1 << k) : 12'h000;
            wr_reg(8'h00, ((i & 1) << (k + 1)) | (i >> 1));
            clr <= 1'b1;
            @(posedge clk);
            clr <= 1'b0;
            flt[4 * k] <= 1'b1;
            repeat (8) @(posedge clk);
            #1 chk(seen, e);
            chk(irq, e != 0);
            rd_chk(aiag_pkg::OFS_STATUS, e != 0);
            flt <= 12'h000;
            wr_reg(aiag_pkg::OFS_STATUS, 32'hff);
            repeat (5) @(posedge clk);
            #1 chk(irq, 1'b0);
         end
      for (i = 0; i < 60; i++)
      begin
         ch = $urandom % 4;
         cf = {2'(i % 4), 6'($urandom)};
         lo = pick(cf[7:6]);
         hi = pick(cf[7:6]);
         wr_reg(8'(16 + 4 * ch), lo);
         wr_reg(8'(32 + 4 * ch), hi);
         wr_reg(8'(4 * ch), cf);
         sel = $urandom % 4;
         s = (sel == 0) ? lo : (sel == 1) ? hi : (sel == 2) ? lo - 16'h1 : 16'($urandom);
         v = {$urandom, $urandom};
         v[16 * ch +: 16] = s;
         sample <= v;
         sample_vld <= 4'(1 << ch);
         @(posedge clk);
         sample_vld <= 4'h0;
         #1 chk(proc_cause, exp_proc(cf, s, lo, hi) << (2 * ch));
         chk(diag_log, 4'h0);
         chk(proc_alarm, 4'(|exp_proc(cf, s, lo, hi)) << ch);
      end
      summarize();
   end
endmodule // analog_input_alarm_gating_bench
